//--- serial_block_link_controller_tb.sv
// self-checking bench of the serial line controller against the modem model
module serial_block_link_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import slc_pkg::*;
  localparam int BLK = 4;
  // ********************************************************************
  // signals and instances
  // ********************************************************************
  logic ref_clk = 1'b0;
  logic srst;
  slc_mode_t mode_sel;
  slc_word_t tx_in;
  logic tx_ready;
  slc_word_t rx_out;
  logic int_clr;
  logic err_clr;
  slc_stat_t status;
  logic lk_clk;
  logic lk_rx_bit;
  logic lk_tx_bit;
  int num_errors = 0;
  int checked = 0;
  int blk_cnt = 0;
  logic [11:0] got[$];
  logic [11:0] sent[$];

  always #2.5 ref_clk = ~ref_clk;

  slc_serial_line_controller #(.BLK_WORDS(BLK)) slc_serial_line_controller_i (
    .ref_clk(ref_clk), .srst(srst), .mode_sel(mode_sel), .tx_in(tx_in), .tx_ready(tx_ready),
    .rx_out(rx_out), .int_clr(int_clr), .err_clr(err_clr), .status(status), .lk_clk(lk_clk),
    .lk_rx_bit(lk_rx_bit), .lk_tx_bit(lk_tx_bit));

  slc_modem_model slc_modem_model_i (.lk_clk(lk_clk), .lk_tx_bit(lk_tx_bit), .lk_rx_bit(lk_rx_bit));

  always @(posedge ref_clk) begin
    if (status.blk_done === 1'b1) blk_cnt++;
    if (rx_out.valid === 1'b1) got.push_back(rx_out.data);
  end
  // ********************************************************************
  // helpers
  // ********************************************************************
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // reference division, msb first, cleared per block
  function automatic logic [11:0] crc_of(input logic [11:0] q[$]);
    logic [11:0] c;
    logic fb;
    c = SLC_CRC_INIT;
    foreach (q[k]) for (int b = 11; b >= 0; b--) begin
      fb = c[11] ^ q[k][b];
      c = {c[10:0], 1'b0};
      if (fb) c = c ^ SLC_CRC_POLY;
    end
    return c;
  endfunction

  function automatic logic [11:0] rnd_word();
    logic [11:0] w;
    w = 12'($urandom);
    if (w == SLC_SYNC_WORD || w == SLC_INT_WORD) w = w ^ 12'h001;
    return w;
  endfunction

  task automatic set_mode(input slc_mode_t m);
    @(negedge ref_clk);
    mode_sel = m;
    repeat (20) @(negedge ref_clk);
  endtask

  task automatic wait_done(input int n0);
    int t;
    for (t = 0; t < 5000 && blk_cnt == n0; t++) @(posedge ref_clk);
    chk(12'(blk_cnt), 12'(n0 + 1));
  endtask

  task automatic send_word(input logic [11:0] w);
    int t;
    @(negedge ref_clk);
    tx_in.data = w;
    tx_in.valid = 1'b1;
    for (t = 0; t < 2000; t++) begin
      @(posedge ref_clk);
      if (tx_ready === 1'b1) break;
    end
    if (t == 2000) chk(12'h0, 12'h1);
  endtask

  task automatic line_word(input logic [11:0] w);
    for (int b = 11; b >= 0; b--) slc_modem_model_i.rxq.push_back(w[b]);
  endtask

  task automatic next_word(inout int i, output logic [11:0] w);
    for (int b = 0; b < 12; b++) begin
      w = {w[10:0], slc_modem_model_i.txq[i]};
      i++;
    end
  endtask

  // ********************************************************************
  // scenarios
  // ********************************************************************
  task automatic test_tx();
    int i;
    int n0;
    logic [11:0] sh;
    logic [11:0] w;
    sent.delete();
    slc_modem_model_i.txq.delete();
    n0 = blk_cnt;
    set_mode(SLC_MODE_TX);
    for (int k = 0; k < BLK; k++) begin
      w = rnd_word();
      sent.push_back(w);
      send_word(w);
    end
    @(negedge ref_clk);
    tx_in.valid = 1'b0;
    wait_done(n0);
    set_mode(SLC_MODE_IDLE);
    sh = 12'hfff;
    i = 0;
    while (i < slc_modem_model_i.txq.size() && sh !== SLC_SYNC_WORD) begin
      sh = {sh[10:0], slc_modem_model_i.txq[i]};
      i++;
    end
    chk(sh, SLC_SYNC_WORD);
    w = SLC_SYNC_WORD;
    while (w === SLC_SYNC_WORD && i < slc_modem_model_i.txq.size()) next_word(i, w);
    foreach (sent[k]) begin
      chk(w, sent[k]);
      next_word(i, w);
    end
    chk(w, crc_of(sent));
    $display("test tx block done");
  endtask

  task automatic test_rx(input logic [11:0] burst);
    int n0;
    logic [11:0] line_q[$];
    sent.delete();
    for (int k = 0; k < BLK; k++) sent.push_back(k == 2 ? SLC_INT_WORD : rnd_word());
    line_q = sent;
    line_q[1] = line_q[1] ^ burst;
    got.delete();
    n0 = blk_cnt;
    set_mode(SLC_MODE_RX);
    line_word(SLC_SYNC_WORD);
    foreach (line_q[k]) line_word(line_q[k]);
    line_word(crc_of(sent));
    wait_done(n0);
    set_mode(SLC_MODE_IDLE);
    chk(12'(got.size()), 12'(BLK));
    foreach (line_q[k]) chk(got[k], line_q[k]);
    chk(12'(status.crc_err), 12'(burst != 12'h000));
    chk(12'(status.int_seen), 12'h0);
    $display("test rx block done, burst %h", burst);
  endtask

  task automatic test_int();
    int t;
    line_word(SLC_INT_WORD);
    for (t = 0; t < 1000 && status.int_seen !== 1'b1; t++) @(posedge ref_clk);
    chk(12'(status.int_seen), 12'h1);
    @(negedge ref_clk);
    int_clr = 1'b1;
    @(negedge ref_clk);
    int_clr = 1'b0;
    @(negedge ref_clk);
    chk(12'(status.int_seen), 12'h0);
    $display("test interrupt word done");
  endtask

  initial begin
    srst = 1'b1;
    mode_sel = SLC_MODE_IDLE;
    tx_in = '0;
    int_clr = 1'b0;
    err_clr = 1'b0;
    void'($urandom(19));
    repeat (6) @(posedge lk_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk(12'(status), 12'h0);
    chk(12'(tx_ready), 12'h1);
    chk(12'(lk_tx_bit), 12'(SLC_LINE_MARK));
    test_tx();
    test_int();
    test_rx(12'h000);
    test_rx(12'h801);
    @(negedge ref_clk);
    err_clr = 1'b1;
    @(negedge ref_clk);
    err_clr = 1'b0;
    @(negedge ref_clk);
    chk(12'(status.crc_err), 12'h0);
    $display("test error clear done");
    print_verdict();
  end

  // all tests take a few microseconds; the watchdog allows many times that
  initial begin
    #100000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule

//--- slc_crc.sv
// shared package of the line controller and its serial check-code generator
// ********************************************************************
// package
// ********************************************************************
package slc_pkg;
  localparam int SLC_WORD_W = 12;
  localparam int SLC_CNT_W = 8;
  localparam int SLC_BLK_WORDS = 8;
  localparam logic [3:0] SLC_BIT_LAST = 4'hb;
  localparam logic [11:0] SLC_SYNC_WORD = 12'h5a7;
  localparam logic [11:0] SLC_INT_WORD = 12'ha5c;
  localparam logic [11:0] SLC_CRC_POLY = 12'h80f;
  localparam logic [11:0] SLC_CRC_INIT = 12'h000;
  localparam logic SLC_LINE_MARK = 1'b1;

  typedef enum logic [1:0] {
    SLC_MODE_IDLE = 2'b00,
    SLC_MODE_TX = 2'b01,
    SLC_MODE_RX = 2'b10
  } slc_mode_t;

  typedef enum logic [2:0] {
    SLC_L_IDLE = 3'b000,
    SLC_L_TX_SYNC = 3'b001,
    SLC_L_TX_DATA = 3'b010,
    SLC_L_TX_CRC = 3'b011,
    SLC_L_RX_HUNT = 3'b100,
    SLC_L_RX_DATA = 3'b101,
    SLC_L_RX_CRC = 3'b110,
    SLC_L_DONE = 3'b111
  } slc_lstate_t;

  typedef struct packed {
    logic valid;
    logic [SLC_WORD_W-1:0] data;
  } slc_word_t;

  typedef struct packed {
    logic int_seen;
    logic crc_err;
    logic blk_done;
  } slc_stat_t;

  typedef struct packed {
    slc_mode_t mode;
    logic ack_s1;
    logic ack_s2;
    logic rxt_s1;
    logic rxt_s2;
    logic rxt_s3;
    logic int_s1;
    logic int_s2;
    logic int_s3;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic tx_tgl;
    logic tx_free;
    logic [SLC_WORD_W-1:0] tx_hold;
    slc_word_t rx;
    slc_stat_t stat;
  } slc_host_st_t;

  typedef struct packed {
    slc_mode_t mode_s1;
    slc_mode_t mode_s2;
    logic req_s1;
    logic req_s2;
    logic rx_s1;
    logic rx_s2;
    slc_lstate_t state;
    logic [3:0] bit_cnt;
    logic [SLC_CNT_W-1:0] word_cnt;
    logic [SLC_WORD_W-1:0] sh;
    logic [SLC_WORD_W-1:0] next_word;
    logic have_word;
    logic ack_tgl;
    logic [SLC_WORD_W-1:0] hunt;
    logic [SLC_WORD_W-1:0] rx_word;
    logic rx_tgl;
    logic int_tgl;
    logic done_tgl;
    logic crc_err;
    logic tx_bit;
  } slc_link_st_t;
endpackage

// ********************************************************************
// serial check-code generator, msb-first division by the polynomial
// ********************************************************************
module slc_crc #(
  parameter int W = 12,
  parameter logic [W-1:0] POLY = 12'h80f,
  parameter logic [W-1:0] INIT = 12'h000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire logic din,
  output logic [W-1:0] crc
);
  typedef struct packed {
    logic [W-1:0] rem;
  } slc_crc_st_t;

  slc_crc_st_t st_r;
  slc_crc_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.rem = INIT;
    end else if (en) begin
      st_nxt.rem = {st_r.rem[W-2:0], 1'b0} ^ ((din ^ st_r.rem[W-1]) ? POLY : '0);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.rem <= INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign crc = st_r.rem;
endmodule

//--- slc_modem_model.sv
// behavioural model of the synchronous modem on the far side of the line controller
module slc_modem_model (
  output logic lk_clk,
  input wire logic lk_tx_bit,
  output logic lk_rx_bit = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************************
  // bit clock and bit queues
  // ********************************************************************
  logic txq[$];
  logic rxq[$];

  // free-running oscillator, phase offset keeps it unrelated to ref_clk
  initial begin
    lk_clk = 1'b0;
    #2.3;
    forever #6 lk_clk = ~lk_clk;
  end

  // modem clocks each transmit bit out of the controller on its own edge
  always @(posedge lk_clk) begin
    txq.push_back(lk_tx_bit);
  end

  // receive bits change on the falling edge; an empty queue means idle mark
  always @(negedge lk_clk) begin
    if (rxq.size() > 0) begin
      lk_rx_bit <= rxq.pop_front();
    end else begin
      lk_rx_bit <= 1'b1;
    end
  end
endmodule

//--- slc_serial_line_controller.sv
// serial line controller: host word port on ref_clk, modem bit link on the modem clock
// Function
// - transmit shifts each 12-bit host word out serially
// - receive assembles serial bits into 12-bit words
// - check code catches bursts of twelve bits
// - check code computed and sent after block
// - interrupt word accepted only when idle
// - interrupt word sets a sticky status bit
// - host command puts controller in tx or rx
// - all bit timing from modem clock only
// - words are sent most significant bit first
// - one direction at a time, swap via idle
// - transmit starts with a sync word
// - received code mismatch sets error status
module slc_serial_line_controller
  import slc_pkg::*;
#(
  parameter int BLK_WORDS = slc_pkg::SLC_BLK_WORDS,
  parameter logic [11:0] SYNC_WORD = slc_pkg::SLC_SYNC_WORD,
  parameter logic [11:0] INT_WORD = slc_pkg::SLC_INT_WORD,
  parameter logic [11:0] CRC_POLY = slc_pkg::SLC_CRC_POLY
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire slc_pkg::slc_mode_t mode_sel,
  input wire slc_pkg::slc_word_t tx_in,
  output logic tx_ready,
  output slc_pkg::slc_word_t rx_out,
  input wire logic int_clr,
  input wire logic err_clr,
  output slc_pkg::slc_stat_t status,
  input wire logic lk_clk,
  input wire logic lk_rx_bit,
  output logic lk_tx_bit
);
  import slc_pkg::*;

  slc_host_st_t hst_r;
  slc_host_st_t h_nxt;
  slc_link_st_t lnk_r;
  slc_link_st_t l_nxt;
  logic lk_rst_s1;
  logic lk_rst_r;
  logic crc_clr;
  logic crc_en;
  logic crc_din;
  logic [SLC_WORD_W-1:0] crc_q;
  logic boundary;
  logic last_word;

  // ********************************************************************
  // host side, ref_clk domain
  // ********************************************************************
  // words cross as quasi-static data beside a toggle; the far register
  // holds for a whole word time, far longer than the three-flop delay
  always_comb begin
    h_nxt = hst_r;
    h_nxt.mode = mode_sel;
    h_nxt.ack_s1 = lnk_r.ack_tgl;
    h_nxt.ack_s2 = hst_r.ack_s1;
    h_nxt.rxt_s1 = lnk_r.rx_tgl;
    h_nxt.rxt_s2 = hst_r.rxt_s1;
    h_nxt.rxt_s3 = hst_r.rxt_s2;
    h_nxt.int_s1 = lnk_r.int_tgl;
    h_nxt.int_s2 = hst_r.int_s1;
    h_nxt.int_s3 = hst_r.int_s2;
    h_nxt.done_s1 = lnk_r.done_tgl;
    h_nxt.done_s2 = hst_r.done_s1;
    h_nxt.done_s3 = hst_r.done_s2;
    h_nxt.rx.valid = 1'b0;
    h_nxt.stat.blk_done = 1'b0;
    if (tx_in.valid && hst_r.tx_free) begin
      h_nxt.tx_hold = tx_in.data;
      h_nxt.tx_tgl = ~hst_r.tx_tgl;
    end
    // compare against the second sync flop only, never the first
    h_nxt.tx_free = (h_nxt.tx_tgl == hst_r.ack_s2);
    if (hst_r.rxt_s2 != hst_r.rxt_s3) begin
      h_nxt.rx.valid = 1'b1;
      h_nxt.rx.data = lnk_r.rx_word;
    end
    // set wins over clear on both sticky bits
    if (int_clr) begin
      h_nxt.stat.int_seen = 1'b0;
    end
    if (hst_r.int_s2 != hst_r.int_s3) begin
      h_nxt.stat.int_seen = 1'b1;
    end
    if (err_clr) begin
      h_nxt.stat.crc_err = 1'b0;
    end
    if (hst_r.done_s2 != hst_r.done_s3) begin
      h_nxt.stat.blk_done = 1'b1;
      if (lnk_r.crc_err) begin
        h_nxt.stat.crc_err = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hst_r <= '0;
      hst_r.tx_free <= 1'b1;
    end else begin
      hst_r <= h_nxt;
    end
  end

  assign tx_ready = hst_r.tx_free;
  assign rx_out = hst_r.rx;
  assign status = hst_r.stat;

  // ********************************************************************
  // link side, modem clock domain
  // ********************************************************************
  always_ff @(posedge lk_clk) begin
    lk_rst_s1 <= srst;
    lk_rst_r <= lk_rst_s1;
  end

  slc_crc #(
    .W(SLC_WORD_W),
    .POLY(CRC_POLY),
    .INIT(SLC_CRC_INIT)
  ) u_crc (
    .clk(lk_clk),
    .rst(lk_rst_r),
    .clr(crc_clr),
    .en(crc_en),
    .din(crc_din),
    .crc(crc_q)
  );

  assign boundary = (lnk_r.bit_cnt == SLC_BIT_LAST);
  assign last_word = (lnk_r.word_cnt == SLC_CNT_W'(BLK_WORDS - 1));

  // every transition below happens on a modem clock edge, never a local one
  always_comb begin
    l_nxt = lnk_r;
    l_nxt.mode_s1 = hst_r.mode;
    l_nxt.mode_s2 = lnk_r.mode_s1;
    l_nxt.req_s1 = hst_r.tx_tgl;
    l_nxt.req_s2 = lnk_r.req_s1;
    l_nxt.rx_s1 = lk_rx_bit;
    l_nxt.rx_s2 = lnk_r.rx_s1;
    l_nxt.hunt = {lnk_r.hunt[SLC_WORD_W-2:0], lnk_r.rx_s2};
    l_nxt.bit_cnt = boundary ? 4'h0 : lnk_r.bit_cnt + 4'h1;
    l_nxt.tx_bit = SLC_LINE_MARK;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_din = lnk_r.sh[SLC_WORD_W-1];
    // one-word prefetch; acked only once captured, so host cannot overrun it
    if ((lnk_r.req_s2 != lnk_r.ack_tgl) && !lnk_r.have_word) begin
      l_nxt.next_word = hst_r.tx_hold;
      l_nxt.have_word = 1'b1;
      l_nxt.ack_tgl = lnk_r.req_s2;
    end
    case (lnk_r.state)
      SLC_L_IDLE: begin
        crc_clr = 1'b1;
        l_nxt.bit_cnt = 4'h0;
        if (lnk_r.mode_s2 == SLC_MODE_TX) begin
          l_nxt.state = SLC_L_TX_SYNC;
          l_nxt.sh = SYNC_WORD;
        end else if (lnk_r.mode_s2 == SLC_MODE_RX) begin
          l_nxt.state = SLC_L_RX_HUNT;
        end else if (l_nxt.hunt == INT_WORD) begin
          l_nxt.int_tgl = ~lnk_r.int_tgl;
          l_nxt.hunt = '0;
        end
      end
      SLC_L_TX_SYNC: begin
        crc_clr = 1'b1;
        l_nxt.tx_bit = lnk_r.sh[SLC_WORD_W-1];
        l_nxt.sh = {lnk_r.sh[SLC_WORD_W-2:0], 1'b0};
        if (boundary) begin
          // repeat sync as fill until the host supplies the first word
          if (lnk_r.have_word) begin
            l_nxt.sh = lnk_r.next_word;
            l_nxt.have_word = 1'b0;
            l_nxt.word_cnt = '0;
            l_nxt.state = SLC_L_TX_DATA;
          end else begin
            l_nxt.sh = SYNC_WORD;
          end
        end
      end
      SLC_L_TX_DATA: begin
        crc_en = 1'b1;
        l_nxt.tx_bit = lnk_r.sh[SLC_WORD_W-1];
        l_nxt.sh = {lnk_r.sh[SLC_WORD_W-2:0], 1'b0};
        if (boundary) begin
          l_nxt.word_cnt = lnk_r.word_cnt + SLC_CNT_W'(1);
          if (last_word) begin
            l_nxt.state = SLC_L_TX_CRC;
          end else if (lnk_r.have_word) begin
            l_nxt.sh = lnk_r.next_word;
            l_nxt.have_word = 1'b0;
          end else begin
            // mid-block underrun sends zeros: the line cannot be paused; a word
            // captured in this same cycle stays held for the next slot
            l_nxt.sh = '0;
          end
        end
      end
      SLC_L_TX_CRC: begin
        l_nxt.tx_bit = crc_q[SLC_BIT_LAST - lnk_r.bit_cnt];
        if (boundary) begin
          l_nxt.crc_err = 1'b0;
          l_nxt.done_tgl = ~lnk_r.done_tgl;
          l_nxt.state = SLC_L_DONE;
        end
      end
      SLC_L_RX_HUNT: begin
        crc_clr = 1'b1;
        l_nxt.bit_cnt = 4'h0;
        if (l_nxt.hunt == SYNC_WORD) begin
          l_nxt.word_cnt = '0;
          l_nxt.state = SLC_L_RX_DATA;
        end
      end
      SLC_L_RX_DATA: begin
        crc_en = 1'b1;
        crc_din = lnk_r.rx_s2;
        if (boundary) begin
          // extra sync fill ahead of data is dropped; first data word may not equal sync
          if ((lnk_r.word_cnt == '0) && (l_nxt.hunt == SYNC_WORD)) begin
            crc_clr = 1'b1;
          end else begin
            l_nxt.rx_word = l_nxt.hunt;
            l_nxt.rx_tgl = ~lnk_r.rx_tgl;
            l_nxt.word_cnt = lnk_r.word_cnt + SLC_CNT_W'(1);
            if (last_word) begin
              l_nxt.state = SLC_L_RX_CRC;
            end
          end
        end
      end
      SLC_L_RX_CRC: begin
        if (boundary) begin
          l_nxt.crc_err = (l_nxt.hunt != crc_q);
          l_nxt.done_tgl = ~lnk_r.done_tgl;
          l_nxt.state = SLC_L_DONE;
        end
      end
      SLC_L_DONE: begin
        l_nxt.bit_cnt = 4'h0;
      end
      default: begin
        l_nxt.state = SLC_L_IDLE;
      end
    endcase
    // dropping the command aborts either direction; tx and rx swap only through idle
    if ((lnk_r.mode_s2 == SLC_MODE_IDLE) && (lnk_r.state != SLC_L_IDLE)) begin
      l_nxt.state = SLC_L_IDLE;
      l_nxt.tx_bit = SLC_LINE_MARK;
    end
  end

  always_ff @(posedge lk_clk) begin
    if (lk_rst_r) begin
      lnk_r <= '0;
      lnk_r.tx_bit <= SLC_LINE_MARK;
    end else begin
      lnk_r <= l_nxt;
    end
  end

  assign lk_tx_bit = lnk_r.tx_bit;

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence s_crc_start;
    lnk_r.state == SLC_L_TX_DATA && boundary && last_word;
  endsequence

  sequence s_crc_first_bit;
    ##1 lnk_r.state == SLC_L_TX_CRC ##1 lnk_r.tx_bit == $past(crc_q[SLC_WORD_W-1]);
  endsequence

  chk_tx_sync_first: assert property (
    @(posedge lk_clk) disable iff (lk_rst_r)
    (lnk_r.state == SLC_L_IDLE && lnk_r.mode_s2 == SLC_MODE_TX)
    |=> (lnk_r.state == SLC_L_TX_SYNC && lnk_r.sh == SYNC_WORD))
    else $error("transmit did not open with the sync word");

  chk_tx_msb_first: assert property (
    @(posedge lk_clk) disable iff (lk_rst_r)
    (lnk_r.state == SLC_L_TX_DATA && lnk_r.mode_s2 == SLC_MODE_TX)
    |=> lnk_r.tx_bit == $past(lnk_r.sh[SLC_WORD_W-1]))
    else $error("transmit bit is not the top bit of the shifter");

  chk_tx_crc_sent: assert property (
    @(posedge lk_clk) disable iff (lk_rst_r)
    (s_crc_start and lnk_r.mode_s2 == SLC_MODE_TX) |-> s_crc_first_bit)
    else $error("check code did not follow the last data word");

  chk_rx_word_build: assert property (
    @(posedge lk_clk) disable iff (lk_rst_r)
    $changed(lnk_r.rx_tgl) |-> lnk_r.rx_word == lnk_r.hunt)
    else $error("received word differs from the shifted bits");

  chk_int_idle_only: assert property (
    @(posedge lk_clk) disable iff (lk_rst_r)
    $changed(lnk_r.int_tgl) |-> ($past(lnk_r.state) == SLC_L_IDLE && $past(lnk_r.mode_s2) == SLC_MODE_IDLE))
    else $error("interrupt word taken while busy");

  chk_crc_block_clear: assert property (
    @(posedge lk_clk) disable iff (lk_rst_r)
    (lnk_r.state == SLC_L_TX_SYNC || lnk_r.state == SLC_L_RX_HUNT) |=> crc_q == SLC_CRC_INIT)
    else $error("check code not cleared at block start");

  chk_rx_crc_compare: assert property (
    @(posedge lk_clk) disable iff (lk_rst_r)
    (lnk_r.state == SLC_L_RX_CRC && boundary && lnk_r.mode_s2 == SLC_MODE_RX)
    |=> (lnk_r.crc_err == (lnk_r.hunt != $past(crc_q))) && lnk_r.state == SLC_L_DONE)
    else $error("check code compare result wrong");

  chk_idle_abort: assert property (
    @(posedge lk_clk) disable iff (lk_rst_r)
    lnk_r.mode_s2 == SLC_MODE_IDLE |=> lnk_r.state == SLC_L_IDLE && lnk_r.tx_bit == SLC_LINE_MARK)
    else $error("link did not return to idle");

  chk_int_status_set: assert property (
    @(posedge ref_clk) disable iff (srst)
    (hst_r.int_s2 != hst_r.int_s3) |=> hst_r.stat.int_seen ##1 (hst_r.stat.int_seen || $past(int_clr)))
    else $error("interrupt word did not set status");

  chk_tx_accept: assert property (
    @(posedge ref_clk) disable iff (srst)
    (tx_in.valid && tx_ready) |=> !tx_ready && hst_r.tx_hold == $past(tx_in.data))
    else $error("host word not taken");
endmodule
